// file: ldpr_pkg.sv
package ldpr_pkg;

   // ========================================
   // array geometry
   localparam int LDPR_ARRAY_BITS = 589824;
   localparam int LDPR_LANE_W = 9;
   localparam int LDPR_BYTE_W = 8;
   localparam int LDPR_LANES = LDPR_ARRAY_BITS / LDPR_LANE_W;
   localparam int LDPR_ADDR_W = 16;
   localparam int LDPR_PORT_DW = 72;
   localparam int LDPR_PORT_MW = 8;
   localparam int LDPR_WIDE_DW = 144;
   localparam int LDPR_WIDE_MW = 16;
   localparam int LDPR_TDP_MAX_W = 72;
   localparam int LDPR_DEF_WIDTH = 72;

   // ========================================
   // reset values
   localparam logic [LDPR_ADDR_W-1:0] LDPR_RST_ADDR = 16'h0000;
   localparam logic [LDPR_PORT_DW-1:0] LDPR_RST_DATA = 72'h0;

   // ========================================
   // types
   typedef logic [LDPR_LANE_W-1:0] ldpr_lane_type;

   typedef enum {
      LDPR_TRUE_DUAL,
      LDPR_SIMPLE_DUAL,
      LDPR_SINGLE,
      LDPR_FIFO
   } ldpr_mode_type;

   // ========================================
   // geometry helpers
   function automatic int ldpr_lane_w(input int w);
      return (w % LDPR_LANE_W == 0) ? LDPR_LANE_W : LDPR_BYTE_W;
   endfunction : ldpr_lane_w

   function automatic bit ldpr_width_ok(input int w);
      int lw;
      int n;
      lw = ldpr_lane_w(w);
      n = w / lw;
      return (w > 0) && (n * lw == w) && ((n & (n - 1)) == 0) && (n <= LDPR_WIDE_MW);
   endfunction : ldpr_width_ok

endpackage : ldpr_pkg

// file: ldpr_in_reg.sv
`timescale 1ns/1ps

module ldpr_in_reg
   import ldpr_pkg::*;
#(
   parameter int DW = LDPR_PORT_DW,
   parameter int MW = LDPR_PORT_MW
) (
   input logic sys_clk_i,
   input logic rst_n_i,
   input logic ce_i,
   input logic clr_i,
   input logic we_i,
   input logic [LDPR_ADDR_W-1:0] addr_i,
   input logic [DW-1:0] data_i,
   input logic [MW-1:0] mask_i,
   output logic we_o,
   output logic [LDPR_ADDR_W-1:0] addr_o,
   output logic [DW-1:0] data_o,
   output logic [MW-1:0] mask_o,
   output logic act_o
);

   if (DW != MW * LDPR_LANE_W) begin : g_bad_dw
      $error("input stage width does not match mask lanes");
   end

   typedef struct packed {
      logic we;
      logic [LDPR_ADDR_W-1:0] addr;
      logic [DW-1:0] data;
      logic [MW-1:0] mask;
      logic act;
   } ldpr_in_type;

   ldpr_in_type st_ff;
   ldpr_in_type nxt_st;

   // ========================================
   // capture stage
   always_comb begin
      nxt_st = st_ff;
      nxt_st.act = 1'b0;
      if (clr_i) begin
         nxt_st = '0;
      end else if (ce_i) begin
         nxt_st.we = we_i;
         nxt_st.addr = addr_i;
         nxt_st.data = data_i;
         nxt_st.mask = mask_i;
         nxt_st.act = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign we_o = st_ff.we;
   assign addr_o = st_ff.addr;
   assign data_o = st_ff.data;
   assign mask_o = st_ff.mask;
   assign act_o = st_ff.act;

   // ========================================
   // checks
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   property p_capture;
      ce_i && !clr_i |=> act_o && (addr_o == $past(addr_i)) && (we_o == $past(we_i));
   endproperty
   a_capture: assert property (p_capture) else $error("input not captured");

   property p_clear;
      clr_i |=> !act_o && (addr_o == LDPR_RST_ADDR) && !we_o;
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not empty stage");

   property p_hold;
      !ce_i && !clr_i |=> !act_o && $stable(addr_o) && $stable(mask_o);
   endproperty
   a_hold: assert property (p_hold) else $error("stage moved without enable");

endmodule : ldpr_in_reg

// file: ldpr_out_reg.sv
`timescale 1ns/1ps

module ldpr_out_reg
   import ldpr_pkg::*;
#(
   parameter bit BYPASS = 1'b0
) (
   input logic sys_clk_i,
   input logic rst_n_i,
   input logic ce_i,
   input logic clr_i,
   input logic [LDPR_PORT_DW-1:0] data_i,
   input logic vld_i,
   output logic [LDPR_PORT_DW-1:0] data_o,
   output logic vld_o
);

   // ========================================
   // optional output stage
   if (BYPASS) begin : g_bypass
      assign data_o = data_i;
      assign vld_o = vld_i;
   end else begin : g_reg
      typedef struct packed {
         logic [LDPR_PORT_DW-1:0] data;
         logic vld;
      } ldpr_out_type;

      ldpr_out_type st_ff;
      ldpr_out_type nxt_st;

      always_comb begin
         nxt_st = st_ff;
         nxt_st.vld = 1'b0;
         if (clr_i) begin
            nxt_st.data = LDPR_RST_DATA;
         end else if (ce_i) begin
            nxt_st.data = data_i;
            nxt_st.vld = vld_i;
         end
      end

      always_ff @(posedge sys_clk_i) begin
         if (!rst_n_i) begin
            st_ff <= '0;
         end else begin
            st_ff <= nxt_st;
         end
      end

      assign data_o = st_ff.data;
      assign vld_o = st_ff.vld;

      property p_out_stage;
         @(posedge sys_clk_i) disable iff (!rst_n_i)
         ce_i && !clr_i |=> (data_o == $past(data_i)) && (vld_o == $past(vld_i));
      endproperty
      a_out_stage: assert property (p_out_stage) else $error("output stage lost data");

      property p_out_clear;
         @(posedge sys_clk_i) disable iff (!rst_n_i)
         clr_i |=> !vld_o && (data_o == LDPR_RST_DATA);
      endproperty
      a_out_clear: assert property (p_out_clear) else $error("output not cleared");
   end

endmodule : ldpr_out_reg

// file: ldpr_ram.sv
`timescale 1ns/1ps

// Functional notes
// - array holds 589,824 bits including parity; every geometry maps onto it.
// - configurable as true dual-port, simple dual-port or single-port RAM; FIFO mode acts as simple dual-port.
// - no preload; contents undefined after power-up until written.
// - data, address, write control and mask are registered before use.
// - read output register is optional; bypass drops that pipeline stage.
// - geometries 64Kx8/9, 32Kx16/18, 16Kx32/36, 8Kx64/72, 4Kx128/144.
// - 4K-word 128/144-bit geometry refused in true dual-port mode.
// - simple dual-port widths 9..72 pair freely; 144 pairs only with 144.
// - true dual-port ports take 9, 18, 36 or 72 independently.
// - write-enable high means write, low means read; no read enable.
// - write needs write-enable and mask lane; mask lanes default high.
// - masking only at 16/18, 32/36, 64/72 bit writes and combined 128/144 mode.
// - mask bit i gates data bits 9i+8 down to 9i.
// - 144-bit mode joins both 8-bit masks into 16 lane enables.
// - any mask combination accepted, including all off and all on.
// - widths 16, 32, 64, 128 mask 8-bit bytes instead of 9-bit lanes.
// - all input registers and output registers share one clock, sys_clk_i.
// - each port has 72 write data inputs and 72 read outputs.
// - clear and clock enable act on their own port's registers; in 144-bit mode port b's enable also loads port a's read register.
module ldpr_ram
   import ldpr_pkg::*;
#(
   parameter ldpr_mode_type MODE = LDPR_TRUE_DUAL,
   parameter int WIDTH_A = LDPR_DEF_WIDTH,
   parameter int WIDTH_B = LDPR_DEF_WIDTH,
   parameter bit OUT_REG_A = 1'b1,
   parameter bit OUT_REG_B = 1'b1
) (
   input logic sys_clk_i,
   input logic rst_n_i,
   input logic ce_a_i,
   input logic clr_a_i,
   input logic wr_en_a_i,
   input logic [LDPR_ADDR_W-1:0] addr_a_i,
   input logic [LDPR_PORT_DW-1:0] wr_data_a_i,
   input logic [LDPR_PORT_MW-1:0] byte_mask_a_i,
   output logic [LDPR_PORT_DW-1:0] rd_data_a_o,
   output logic rd_valid_a_o,
   input logic ce_b_i,
   input logic clr_b_i,
   input logic wr_en_b_i,
   input logic [LDPR_ADDR_W-1:0] addr_b_i,
   input logic [LDPR_PORT_DW-1:0] wr_data_b_i,
   input logic [LDPR_PORT_MW-1:0] byte_mask_b_i,
   output logic [LDPR_PORT_DW-1:0] rd_data_b_o,
   output logic rd_valid_b_o
);

   // ========================================
   // geometry
   localparam int LW_A = ldpr_lane_w(WIDTH_A);
   localparam int LW_B = ldpr_lane_w(WIDTH_B);
   localparam int L_A = WIDTH_A / LW_A;
   localparam int L_B = WIDTH_B / LW_B;
   localparam int SH_A = $clog2(L_A);
   localparam int SH_B = $clog2(L_B);
   localparam int HALF_A = LW_A * LDPR_PORT_MW;
   localparam int HALF_B = LW_B * LDPR_PORT_MW;
   localparam bit WIDE = (WIDTH_A > LDPR_TDP_MAX_W);
   localparam bit TDP = (MODE == LDPR_TRUE_DUAL);
   localparam bit SINGLE = (MODE == LDPR_SINGLE);
   localparam bit A_RD = TDP || SINGLE;
   localparam bit B_WR = TDP;
   localparam bit B_RD = !SINGLE;

   // ========================================
   // elaboration checks
   if (!ldpr_width_ok(WIDTH_A) || !ldpr_width_ok(WIDTH_B)) begin : g_bad_width
      $error("unsupported port width");
   end

   if (!SINGLE && (LW_A != LW_B)) begin : g_bad_family
      $error("parity and byte widths cannot be mixed");
   end

   if (TDP && ((WIDTH_A > LDPR_TDP_MAX_W) || (WIDTH_B > LDPR_TDP_MAX_W))) begin : g_bad_tdp
      $error("widest geometry not available in true dual-port");
   end

   if (!TDP && !SINGLE && (WIDE || (WIDTH_B > LDPR_TDP_MAX_W))
       && (WIDTH_A != WIDTH_B)) begin : g_bad_sdp
      $error("widest geometry must pair with itself");
   end

   if (SINGLE && WIDE) begin : g_bad_single
      $error("widest geometry needs simple dual-port");
   end

   if (LDPR_LANES * LDPR_LANE_W != LDPR_ARRAY_BITS) begin : g_bad_array
      $error("array size mismatch");
   end

   // ========================================
   // state
   typedef struct packed {
      logic [LDPR_PORT_DW-1:0] rd_a;
      logic [LDPR_PORT_DW-1:0] rd_b;
      logic vld_a;
      logic vld_b;
      logic chk_wr;
      logic chk_on;
      logic [LDPR_ADDR_W-1:0] chk_idx;
      ldpr_lane_type chk_old;
      ldpr_lane_type chk_new;
   } ldpr_st_type;

   ldpr_st_type st_ff;
   ldpr_st_type nxt_st;

   ldpr_lane_type mem [LDPR_LANES];

   logic [LDPR_WIDE_DW-1:0] cmp_dat_a;
   logic [LDPR_WIDE_MW-1:0] cmp_msk_a;
   logic iwe_a;
   logic iwe_b;
   logic iact_a;
   logic iact_b;
   logic [LDPR_ADDR_W-1:0] iaddr_a;
   logic [LDPR_ADDR_W-1:0] iaddr_b;
   logic [LDPR_WIDE_DW-1:0] idat_a;
   logic [LDPR_PORT_DW-1:0] idat_b;
   logic [LDPR_WIDE_MW-1:0] imsk_a;
   logic [LDPR_PORT_MW-1:0] imsk_b;
   logic [LDPR_ADDR_W-1:0] base_a;
   logic [LDPR_ADDR_W-1:0] base_b;
   logic [LDPR_WIDE_MW-1:0] lane_on_a;
   logic [LDPR_PORT_MW-1:0] lane_on_b;
   logic write_a;
   logic write_b;
   logic read_strobe_a;
   logic read_strobe_b;
   logic [LDPR_WIDE_DW-1:0] rvec_a;
   logic [LDPR_WIDE_DW-1:0] rvec_b;
   logic src_strobe_a;
   logic [LDPR_PORT_DW-1:0] src_data_a;
   logic [LDPR_PORT_DW-1:0] src_data_b;

   // ========================================
   // write port assembly
   always_comb begin
      cmp_dat_a = '0;
      cmp_msk_a = '0;
      if (WIDE) begin
         cmp_dat_a[HALF_A-1:0] = wr_data_a_i[HALF_A-1:0];
         cmp_dat_a[2*HALF_A-1:HALF_A] = wr_data_b_i[HALF_A-1:0];
         cmp_msk_a = {byte_mask_b_i, byte_mask_a_i};
      end else begin
         cmp_dat_a[LDPR_PORT_DW-1:0] = wr_data_a_i;
         cmp_msk_a[LDPR_PORT_MW-1:0] = byte_mask_a_i;
      end
   end

   // ========================================
   // input registers
   ldpr_in_reg #(
      .DW(LDPR_WIDE_DW),
      .MW(LDPR_WIDE_MW)
   ) u_in_a (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_a_i),
      .clr_i(clr_a_i),
      .we_i(wr_en_a_i),
      .addr_i(addr_a_i),
      .data_i(cmp_dat_a),
      .mask_i(cmp_msk_a),
      .we_o(iwe_a),
      .addr_o(iaddr_a),
      .data_o(idat_a),
      .mask_o(imsk_a),
      .act_o(iact_a)
   );

   ldpr_in_reg #(
      .DW(LDPR_PORT_DW),
      .MW(LDPR_PORT_MW)
   ) u_in_b (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_b_i),
      .clr_i(clr_b_i),
      .we_i(wr_en_b_i),
      .addr_i(addr_b_i),
      .data_i(wr_data_b_i),
      .mask_i(byte_mask_b_i),
      .we_o(iwe_b),
      .addr_o(iaddr_b),
      .data_o(idat_b),
      .mask_o(imsk_b),
      .act_o(iact_b)
   );

   // ========================================
   // lane decode
   assign base_a = LDPR_ADDR_W'(iaddr_a << SH_A);
   assign base_b = LDPR_ADDR_W'(iaddr_b << SH_B);
   assign write_a = iact_a && iwe_a;
   assign write_b = B_WR && iact_b && iwe_b;
   assign read_strobe_a = A_RD && iact_a && !iwe_a;
   assign read_strobe_b = B_RD && iact_b && !iwe_b;

   for (genvar g = 0; g < LDPR_WIDE_MW; g++) begin : g_lane_a
      assign lane_on_a[g] = (L_A == 1) || imsk_a[g];
   end

   for (genvar g = 0; g < LDPR_PORT_MW; g++) begin : g_lane_b
      assign lane_on_b[g] = (L_B == 1) || imsk_b[g];
   end

   // ========================================
   // array, no reset and no preload
   always_ff @(posedge sys_clk_i) begin
      for (int k = 0; k < LDPR_WIDE_MW; k++) begin
         if (write_a && (k < L_A) && lane_on_a[k]) begin
            mem[LDPR_ADDR_W'(base_a + k)] <= ldpr_lane_type'(idat_a[k*LW_A +: LW_A]);
         end
      end
      for (int k = 0; k < LDPR_PORT_MW; k++) begin
         if (write_b && (k < L_B) && lane_on_b[k]) begin
            mem[LDPR_ADDR_W'(base_b + k)] <= ldpr_lane_type'(idat_b[k*LW_B +: LW_B]);
         end
      end
   end

   // ========================================
   // array read
   always_comb begin
      rvec_a = '0;
      rvec_b = '0;
      for (int k = 0; k < LDPR_WIDE_MW; k++) begin
         if (k < L_A) begin
            rvec_a[k*LW_A +: LW_A] = mem[LDPR_ADDR_W'(base_a + k)][LW_A-1:0];
         end
         if (k < L_B) begin
            rvec_b[k*LW_B +: LW_B] = mem[LDPR_ADDR_W'(base_b + k)][LW_B-1:0];
         end
      end
   end

   // ========================================
   // read data steering
   always_comb begin
      if (WIDE) begin
         src_strobe_a = read_strobe_b;
         src_data_a = LDPR_PORT_DW'(rvec_b[HALF_B-1:0]);
         src_data_b = LDPR_PORT_DW'(rvec_b[2*HALF_B-1:HALF_B]);
      end else begin
         src_strobe_a = read_strobe_a;
         src_data_a = rvec_a[LDPR_PORT_DW-1:0];
         src_data_b = rvec_b[LDPR_PORT_DW-1:0];
      end
   end

   // ========================================
   // read registers
   always_comb begin
      nxt_st = st_ff;
      nxt_st.vld_a = 1'b0;
      nxt_st.vld_b = 1'b0;
      if (clr_a_i) begin
         nxt_st.rd_a = LDPR_RST_DATA;
      end else if (src_strobe_a) begin
         nxt_st.rd_a = src_data_a;
         nxt_st.vld_a = 1'b1;
      end
      if (clr_b_i) begin
         nxt_st.rd_b = LDPR_RST_DATA;
      end else if (read_strobe_b) begin
         nxt_st.rd_b = src_data_b;
         nxt_st.vld_b = 1'b1;
      end
      nxt_st.chk_wr = write_a && !write_b;
      nxt_st.chk_on = lane_on_a[0];
      nxt_st.chk_idx = base_a;
      nxt_st.chk_old = mem[base_a];
      nxt_st.chk_new = ldpr_lane_type'(idat_a[LW_A-1:0]);
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ========================================
   // output registers
   ldpr_out_reg #(
      .BYPASS(!OUT_REG_A)
   ) u_out_a (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_a_i),
      .clr_i(clr_a_i),
      .data_i(st_ff.rd_a),
      .vld_i(st_ff.vld_a),
      .data_o(rd_data_a_o),
      .vld_o(rd_valid_a_o)
   );

   ldpr_out_reg #(
      .BYPASS(!OUT_REG_B)
   ) u_out_b (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_b_i),
      .clr_i(clr_b_i),
      .data_i(st_ff.rd_b),
      .vld_i(st_ff.vld_b),
      .data_o(rd_data_b_o),
      .vld_o(rd_valid_b_o)
   );

   // ========================================
   // checks
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   property p_array_bits;
      iact_a |-> ((base_a >> SH_A) == (iaddr_a & LDPR_ADDR_W'((LDPR_LANES >> SH_A) - 1)));
   endproperty
   a_array_bits: assert property (p_array_bits) else $error("array size wrong");

   property p_read_mode;
      iact_a && !iwe_a && !clr_a_i && !WIDE |=> (st_ff.vld_a == A_RD);
   endproperty
   a_read_mode: assert property (p_read_mode) else $error("read not performed");

   property p_write_mode;
      iact_a && iwe_a && !WIDE |=> !st_ff.vld_a;
   endproperty
   a_write_mode: assert property (p_write_mode) else $error("write gave read data");

   sequence s_rd_req_b;
      ce_b_i && !clr_b_i && !wr_en_b_i ##1 !clr_b_i;
   endsequence

   property p_read_latency_b;
      s_rd_req_b |=> (st_ff.vld_b == B_RD);
   endproperty
   a_read_latency_b: assert property (p_read_latency_b) else $error("read late");

   property p_clr_isolated;
      clr_a_i && !clr_b_i && ce_b_i |=> iact_b;
   endproperty
   a_clr_isolated: assert property (p_clr_isolated) else $error("clear leaked");

   property p_write_lane;
      st_ff.chk_wr && st_ff.chk_on |-> (mem[st_ff.chk_idx] == st_ff.chk_new);
   endproperty
   a_write_lane: assert property (p_write_lane) else $error("lane not written");

   property p_keep_masked;
      st_ff.chk_wr && !st_ff.chk_on |-> (mem[st_ff.chk_idx] == st_ff.chk_old);
   endproperty
   a_keep_masked: assert property (p_keep_masked) else $error("masked lane changed");

endmodule : ldpr_ram

// file: ldpr_fabric.sv
`timescale 1ns/1ps

// ========================================
// fabric side driving and collecting port b
module ldpr_fabric
   import ldpr_pkg::*;
(
   input logic sys_clk_i,
   input logic req_i,
   input logic we_i,
   input logic clr_i,
   input logic [LDPR_ADDR_W-1:0] addr_i,
   input logic [LDPR_PORT_DW-1:0] data_i,
   input logic [LDPR_PORT_MW-1:0] mask_i,
   input logic [LDPR_PORT_DW-1:0] rd_data_i,
   input logic rd_valid_i,
   output logic ce_o,
   output logic clr_o,
   output logic we_o,
   output logic [LDPR_ADDR_W-1:0] addr_o,
   output logic [LDPR_PORT_DW-1:0] data_o,
   output logic [LDPR_PORT_MW-1:0] mask_o,
   output logic [3:0][LDPR_PORT_DW-1:0] rd_q_o,
   output int rd_cnt_o
);
   // ========================================
   // per-port enable, clear and write select
   assign ce_o = req_i;
   assign clr_o = clr_i;
   assign we_o = req_i & we_i;
   // idle lines never show the last request
   assign addr_o = req_i ? addr_i : ~addr_i;
   assign data_o = req_i ? data_i : ~data_i;
   assign mask_o = req_i ? mask_i : ~mask_i;

   // ========================================
   // read result collection
   int cnt = 0;
   always @(posedge sys_clk_i) begin
      if (rd_valid_i) begin
         rd_q_o[cnt[1:0]] <= rd_data_i;
         cnt <= cnt + 1;
      end
   end
   assign rd_cnt_o = cnt;
endmodule : ldpr_fabric

// file: large_dual_port_ram_tb.sv
`timescale 1ns/1ps

module large_dual_port_ram_tb
   import ldpr_pkg::*;
;
   logic clk, rst_n, ce_a, clr_a, we_a, b_req, b_we, b_clr;
   logic ce_b, clr_b, we_b, vld_a, vld_b;
   logic [15:0] addr_a, b_addr, addr_b;
   logic [71:0] data_a, b_data, data_b, rd_a, rd_b;
   logic [7:0] mask_a, b_mask, mask_b;
   logic [3:0][71:0] rd_q;
   int rd_cnt, num_errors, total_checks;
   logic [8:0] mem [int];
   logic w_ce_a, w_ce_b, w_we, w_vld_a, w_vld_b;
   logic [15:0] w_addr, wmsk;
   logic [71:0] w_da, w_db, w_rd_a, w_rd_b;
   logic [7:0] w_ma, w_mb;
   logic [143:0] w0, w1;

   ldpr_ram #(.MODE(LDPR_TRUE_DUAL), .WIDTH_A(72), .WIDTH_B(18), .OUT_REG_A(1'b1),
      .OUT_REG_B(1'b0)) DUT (.sys_clk_i(clk), .rst_n_i(rst_n), .ce_a_i(ce_a),
      .clr_a_i(clr_a), .wr_en_a_i(we_a), .addr_a_i(addr_a), .wr_data_a_i(data_a),
      .byte_mask_a_i(mask_a), .rd_data_a_o(rd_a), .rd_valid_a_o(vld_a), .ce_b_i(ce_b),
      .clr_b_i(clr_b), .wr_en_b_i(we_b), .addr_b_i(addr_b), .wr_data_b_i(data_b),
      .byte_mask_b_i(mask_b), .rd_data_b_o(rd_b), .rd_valid_b_o(vld_b));

   ldpr_fabric fab (.sys_clk_i(clk), .req_i(b_req), .we_i(b_we), .clr_i(b_clr),
      .addr_i(b_addr), .data_i(b_data), .mask_i(b_mask), .rd_data_i(rd_b),
      .rd_valid_i(vld_b), .ce_o(ce_b), .clr_o(clr_b), .we_o(we_b), .addr_o(addr_b),
      .data_o(data_b), .mask_o(mask_b), .rd_q_o(rd_q), .rd_cnt_o(rd_cnt));

   ldpr_ram #(.MODE(LDPR_SIMPLE_DUAL), .WIDTH_A(144), .WIDTH_B(144), .OUT_REG_A(1'b0),
      .OUT_REG_B(1'b0)) DUT_W (.sys_clk_i(clk), .rst_n_i(rst_n), .ce_a_i(w_ce_a),
      .clr_a_i(clr_a), .wr_en_a_i(w_we), .addr_a_i(w_addr), .wr_data_a_i(w_da),
      .byte_mask_a_i(w_ma), .rd_data_a_o(w_rd_a), .rd_valid_a_o(w_vld_a), .ce_b_i(w_ce_b),
      .clr_b_i(b_clr), .wr_en_b_i(w_we), .addr_b_i(w_addr), .wr_data_b_i(w_db),
      .byte_mask_b_i(w_mb), .rd_data_b_o(w_rd_b), .rd_valid_b_o(w_vld_b));

   // ========================================
   // clock and watchdog
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      results();
   end

   // ========================================
   // compare and report
   task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic results;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results

   // ========================================
   // lane model: word of l lanes at a uses lanes a*l..a*l+l-1
   function automatic logic [71:0] exp_rd(input int l, input int a);
      logic [71:0] r;
      r = '0;
      for (int k = 0; k < l; k++) r[9*k+:9] = mem[a*l+k];
      return r;
   endfunction : exp_rd

   task automatic wr_mdl(input int l, input int a, input logic [71:0] d, input logic [7:0] m);
      for (int k = 0; k < l; k++) if (m[k]) mem[a*l+k] = d[9*k+:9];
   endtask : wr_mdl

   function automatic logic [143:0] exp_wide(input logic [143:0] d0, input logic [143:0] d1,
      input logic [15:0] m);
      logic [143:0] r;
      r = d0;
      for (int k = 0; k < 16; k++) if (m[k]) r[9*k+:9] = d1[9*k+:9];
      return r;
   endfunction : exp_wide

   // ========================================
   // port tasks, entered at a falling edge
   task automatic a_wr(input int a, input logic [71:0] d, input logic [7:0] m);
      ce_a = 1'b1;
      we_a = 1'b1;
      addr_a = 16'(a);
      data_a = d;
      mask_a = m;
      wr_mdl(8, a, d, m);
      @(negedge clk);
   endtask : a_wr

   task automatic a_rd(input int a);
      ce_a = 1'b1;
      we_a = 1'b0;
      addr_a = 16'(a);
      @(negedge clk);
      chk(72'(vld_a), 72'h0);
      @(negedge clk);
      chk(72'(vld_a), 72'h0);
      @(negedge clk);
      chk(72'(vld_a), 72'h1);
      chk(rd_a, exp_rd(8, a));
      ce_a = 1'b0;
      data_a = ~data_a;
      @(negedge clk);
      chk(72'(vld_a), 72'h0);
   endtask : a_rd

   task automatic b_wr(input int a, input logic [71:0] d, input logic [7:0] m);
      b_req = 1'b1;
      b_we = 1'b1;
      b_addr = 16'(a);
      b_data = d;
      b_mask = m;
      wr_mdl(2, a, d, m);
      @(negedge clk);
      b_req = 1'b0;
   endtask : b_wr

   task automatic b_rd(input int a0);
      int c0;
      c0 = rd_cnt;
      for (int j = 0; j < 4; j++) begin
         b_req = 1'b1;
         b_we = 1'b0;
         b_addr = 16'(a0 + j);
         @(negedge clk);
         chk(72'(vld_b), (j == 0) ? 72'h0 : 72'h1);
      end
      b_req = 1'b0;
      repeat (3) @(negedge clk);
      chk(72'(rd_cnt - c0), 72'h4);
      for (int j = 0; j < 4; j++) chk(rd_q[(c0+j)%4], exp_rd(2, a0 + j));
   endtask : b_rd

   task automatic w_wr(input int a, input logic [143:0] d, input logic [15:0] m);
      w_ce_a = 1'b1;
      w_we = 1'b1;
      w_addr = 16'(a);
      {w_db, w_da} = d;
      {w_mb, w_ma} = m;
      @(negedge clk);
   endtask : w_wr

   task automatic w_rd(input int a, input logic [143:0] e);
      w_ce_a = 1'b0;
      w_we = 1'b0;
      w_ce_b = 1'b1;
      w_addr = 16'(a);
      @(negedge clk);
      w_ce_b = 1'b0;
      @(negedge clk);
      chk(72'({w_vld_a, w_vld_b}), 72'h3);
      chk(w_rd_a, e[71:0]);
      chk(w_rd_b, e[143:72]);
   endtask : w_rd

   // ========================================
   // main sequence
   initial begin
      int a;
      void'($urandom(77411));
      {ce_a, clr_a, we_a, b_req, b_we, b_clr} = '0;
      {addr_a, b_addr, data_a, b_data, mask_a, b_mask} = '0;
      {w_ce_a, w_ce_b, w_we, w_addr, w_da, w_db, w_ma, w_mb} = '0;
      rst_n = 1'b0;
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      chk(rd_a, 72'h0);
      chk(72'(vld_a | vld_b), 72'h0);
      for (int i = 0; i < 8; i++) a_wr(i, 72'({$urandom(), $urandom(), $urandom()}), 8'hFF);
      a_wr(3, ~72'h0, 8'h00);
      a_rd(3);
      a_wr(5, ~72'h0, 8'h80);
      a_rd(5);
      for (int i = 0; i < 40; i++) begin
         a = $urandom_range(7);
         a_wr(a, 72'({$urandom(), $urandom(), $urandom()}), 8'($urandom()));
         a_rd(a);
         b_rd(a * 4);
         b_wr(a * 4 + $urandom_range(3), 72'({$urandom(), $urandom(), $urandom()}),
            8'($urandom()));
         a_rd(a);
      end
      for (int i = 0; i < 8; i++) begin
         a = $urandom_range(4095);
         w0 = 144'({$urandom(), $urandom(), $urandom(), $urandom(), $urandom()});
         w1 = 144'({$urandom(), $urandom(), $urandom(), $urandom(), $urandom()});
         wmsk = (i == 0) ? 16'h0000 : 16'($urandom());
         w_wr(a, w0, 16'hFFFF);
         w_wr(a, w1, wmsk);
         w_rd(a, exp_wide(w0, w1, wmsk));
      end
      b_rd(8);
      clr_a = 1'b1;
      b_req = 1'b1;
      b_we = 1'b0;
      b_addr = 16'h0009;
      @(negedge clk);
      clr_a = 1'b0;
      b_req = 1'b0;
      chk(rd_a, 72'h0);
      chk(rd_b, exp_rd(2, 11));
      @(negedge clk);
      chk(72'(vld_b), 72'h1);
      chk(rd_b, exp_rd(2, 9));
      b_clr = 1'b1;
      @(negedge clk);
      b_clr = 1'b0;
      chk(rd_b, 72'h0);
      chk(rd_a, 72'h0);
      results();
   end
endmodule : large_dual_port_ram_tb
